// File: pkg/dsd_pkg.sv
`default_nettype none
package dsd_pkg;
  // Address space geometry
  localparam int ADDR_W = 16;
  localparam int NEAR_W = 13;
  localparam int DMA_OFF_W = 11;
  localparam logic [15:0] PREG_BASE = 16'h0000;
  localparam logic [15:0] PREG_LAST = 16'h07FF;
  localparam logic [15:0] NEAR_LAST = 16'h1FFF;
  localparam logic [15:0] RAM_BASE = 16'h0800;
  localparam logic [16:0] ADDR_IMPL_TOP = 17'h08000;
  // Default sizes of one device variant
  localparam int RAM_BYTES_DEF = 16384;
  localparam int Y_BASE_DEF = 16'h3800;
  localparam int DMA_BYTES_DEF = 2048;
  // Reset values
  localparam logic [15:0] DATA_RST = 16'h0000;

  // How the CPU forms an effective address
  typedef enum logic [1:0] {
    DSD_AM_NEAR = 2'b00,
    DSD_AM_DIRECT = 2'b01,
    DSD_AM_INDIRECT = 2'b10
  } dsd_mode_t;

  typedef struct packed {
    logic req;
    logic byte_op;
    dsd_mode_t mode;
    logic [NEAR_W-1:0] near_addr;
    logic [ADDR_W-1:0] direct_addr;
    logic [ADDR_W-1:0] pointer;
  } dsd_rd_t;

  typedef struct packed {
    logic req;
    logic [ADDR_W-1:0] pointer;
  } dsd_yrd_t;

  typedef struct packed {
    logic req;
    logic byte_op;
    logic bitrev;
    logic modulo;
    dsd_mode_t mode;
    logic [NEAR_W-1:0] near_addr;
    logic [ADDR_W-1:0] direct_addr;
    logic [ADDR_W-1:0] pointer;
    logic [15:0] data;
  } dsd_wr_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic byte_op;
    logic [DMA_OFF_W-1:0] offset;
    logic [15:0] data;
  } dsd_dma_t;

  typedef struct packed {
    logic we;
    logic byte_op;
    logic [ADDR_W-1:0] addr;
    logic [15:0] data;
  } dsd_preg_wr_t;

  typedef struct packed {
    logic [15:0] x_rdata;
    logic [15:0] y_rdata;
    logic [15:0] dma_rdata;
    dsd_preg_wr_t preg_wr;
    logic collide;
    logic wr_err;
  } dsd_state_t;
endpackage
`default_nettype wire

// File: hdl/dsd_data_space.sv
// Functional notes
// RL1: Lowest 2 KB are peripheral register space.
// RL2: Unimplemented register addresses read as zero.
// RL3: Near space reached by 13-bit field.
// RL4: Whole space by 16-bit direct or pointer.
// RL5: 16-bit byte addresses, 32K words.
// RL6: Two address units, separate data paths.
// RL7: X bus serves unified and X prefetch.
// RL8: Y path reads concurrently for multiply class.
// RL9: Modulo both spaces, bit-reverse X writes only.
// RL10: Writes decoded over unified X plus Y.
// RL11: X/Y boundary fixed, not software changeable.
// RL12: DMA RAM sits at top of Y.
// RL13: CPU and DMA access RAM same cycle.
// RL14: CPU wins write conflicts, never stalled.
// RL15: DMA RAM usable as plain CPU storage.
// RL16: Reads outside implemented memory return zero.
// RL17: Byte write touches only addressed lane.
// RL18: Colliding DMA write data is discarded.
`timescale 1ns/1ps
`default_nettype none
module dsd_data_space #(
  parameter int RAM_BYTES = dsd_pkg::RAM_BYTES_DEF,
  parameter int Y_BASE = dsd_pkg::Y_BASE_DEF,
  parameter int DMA_BYTES = dsd_pkg::DMA_BYTES_DEF
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // CPU read and write requests
  input wire dsd_pkg::dsd_rd_t x_rd_in,
  input wire dsd_pkg::dsd_yrd_t y_rd_in,
  input wire dsd_pkg::dsd_wr_t wr_in,
  // Peripheral register read side
  input wire logic preg_hit_in,
  input wire logic [15:0] preg_rdata_in,
  // DMA controller port
  input wire dsd_pkg::dsd_dma_t dma_in,
  // Answers
  output logic [15:0] x_rdata_out,
  output logic [15:0] y_rdata_out,
  output logic [15:0] dma_rdata_out,
  output dsd_pkg::dsd_preg_wr_t preg_wr_out,
  output logic collide_out,
  output logic wr_err_out
);
  import dsd_pkg::*;

  localparam int WORDS = RAM_BYTES / 2;
  localparam int AW = $clog2(WORDS);
  localparam logic [16:0] RAM_TOP = 17'(RAM_BASE) + 17'(RAM_BYTES);
  localparam logic [16:0] Y_LOW = 17'(Y_BASE); // RL11
  localparam logic [16:0] DMA_LOW = RAM_TOP - 17'(DMA_BYTES);

  // Sizes the decode cannot serve are flagged with an error when simulation starts
  initial begin
    if (RAM_BYTES < 2 * DMA_BYTES || (RAM_BYTES % 2) != 0 ||
        RAM_TOP > ADDR_IMPL_TOP || Y_LOW < 17'(RAM_BASE) ||
        Y_LOW > DMA_LOW || DMA_BYTES > (1 << DMA_OFF_W) ||
        (Y_BASE % 2) != 0 || DMA_BYTES < 2 ||
        (DMA_BYTES % 2) != 0) begin
      $error("dsd_data_space: unsupported memory geometry");
    end
  end

  // Word array covering X and Y; DMA RAM is its top slice
  logic [15:0] mem [WORDS];

  dsd_state_t state_reg;
  dsd_state_t state_next;

  // Effective address from the addressing mode
  function automatic logic [15:0] adr_of(input dsd_mode_t m,
                                         input logic [12:0] n,
                                         input logic [15:0] d,
                                         input logic [15:0] p);
    unique case (m)
      DSD_AM_NEAR: adr_of = {3'h0, n}; // RL3
      DSD_AM_DIRECT: adr_of = d; // RL4
      DSD_AM_INDIRECT: adr_of = p; // RL4
      default: adr_of = 16'h0000;
    endcase
  endfunction

  function automatic logic in_ram(input logic [15:0] adr);
    in_ram = adr >= RAM_BASE && {1'b0, adr} < RAM_TOP; // RL5
  endfunction

  function automatic logic in_y(input logic [15:0] adr);
    in_y = {1'b0, adr} >= Y_LOW && {1'b0, adr} < RAM_TOP;
  endfunction

  function automatic logic [AW-1:0] idx_of(input logic [15:0] adr);
    logic [15:0] off;
    off = adr - RAM_BASE;
    idx_of = off[AW:1];
  endfunction

  // Decoded addresses of this cycle
  logic [15:0] x_adr;
  logic [15:0] w_adr;
  logic [16:0] dma_adr;
  logic [AW-1:0] x_idx;
  logic [AW-1:0] y_idx;
  logic [AW-1:0] w_idx;
  logic [AW-1:0] d_idx;
  logic dma_ok;
  logic cpu_we;
  logic dma_we;
  logic collide_w;
  logic bitrev_bad;
  logic [1:0] cpu_lane;
  logic [1:0] dma_lane;
  logic [15:0] cpu_wdata;
  logic [15:0] dma_wdata;

  // Address generation for read, write and DMA paths
  always_comb begin
    x_adr = adr_of(x_rd_in.mode, x_rd_in.near_addr,
                   x_rd_in.direct_addr, x_rd_in.pointer);
    w_adr = adr_of(wr_in.mode, wr_in.near_addr,
                   wr_in.direct_addr, wr_in.pointer);
    dma_adr = DMA_LOW + 17'(dma_in.offset); // RL12
    dma_ok = 32'(dma_in.offset) < DMA_BYTES;
    x_idx = idx_of(x_adr);
    y_idx = idx_of(y_rd_in.pointer); // RL6
    w_idx = idx_of(w_adr);
    d_idx = idx_of(dma_adr[15:0]);
  end

  // Write decode over the unified space; modulo is legal anywhere,
  // but a bit-reversed address aimed at Y is dropped as an error
  always_comb begin
    bitrev_bad = wr_in.req && wr_in.bitrev && in_y(w_adr); // RL9
    cpu_we = wr_in.req && in_ram(w_adr) && !bitrev_bad; // RL10
    dma_we = dma_in.wr && dma_ok; // RL13
    collide_w = cpu_we && dma_we && w_idx == d_idx; // RL14
    if (wr_in.byte_op) begin
      cpu_lane = w_adr[0] ? 2'b10 : 2'b01; // RL17
      cpu_wdata = {wr_in.data[7:0], wr_in.data[7:0]};
    end else begin
      cpu_lane = 2'b11;
      cpu_wdata = wr_in.data;
    end
    if (dma_in.byte_op) begin
      dma_lane = dma_in.offset[0] ? 2'b10 : 2'b01; // RL17
      dma_wdata = {dma_in.data[7:0], dma_in.data[7:0]};
    end else begin
      dma_lane = 2'b11;
      dma_wdata = dma_in.data;
    end
  end

  // Two write ports; lanes kept apart so a byte write spares the
  // other half. CPU port always proceeds, so the CPU never waits.
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      for (int b = 0; b < 2; b++) begin
        if (cpu_we && cpu_lane[b]) begin
          mem[w_idx][b*8 +: 8] <= cpu_wdata[b*8 +: 8]; // RL15
        end
        if (dma_we && !collide_w && dma_lane[b]) begin
          mem[d_idx][b*8 +: 8] <= dma_wdata[b*8 +: 8]; // RL18
        end
      end
    end
  end

  logic [15:0] x_word;
  logic [15:0] d_word;

  // Read paths and registered answers
  always_comb begin
    state_next = state_reg;
    // X bus: unified view, registers, RAM, or zero
    if (x_adr <= PREG_LAST) begin
      x_word = preg_hit_in ? preg_rdata_in : DATA_RST; // RL2
    end else if (in_ram(x_adr)) begin
      x_word = mem[x_idx]; // RL7
    end else begin
      x_word = DATA_RST; // RL16
    end
    d_word = dma_ok ? mem[d_idx] : DATA_RST;
    if (x_rd_in.req) begin
      if (x_rd_in.byte_op) begin
        state_next.x_rdata = {8'h00,
                              x_adr[0] ? x_word[15:8] : x_word[7:0]};
      end else begin
        state_next.x_rdata = x_word;
      end
    end
    // Y bus runs beside X; only Y addresses answer
    if (y_rd_in.req) begin
      state_next.y_rdata = in_y(y_rd_in.pointer) ?
                           mem[y_idx] : DATA_RST; // RL8
    end
    if (dma_in.rd) begin
      state_next.dma_rdata = d_word; // RL13
    end
    // Register region writes go out to the owning peripheral
    state_next.preg_wr.we = wr_in.req && w_adr <= PREG_LAST; // RL1
    state_next.preg_wr.byte_op = wr_in.byte_op;
    state_next.preg_wr.addr = w_adr;
    state_next.preg_wr.data = wr_in.data;
    state_next.collide = collide_w;
    state_next.wr_err = bitrev_bad;
  end

  // Single state register, frozen while the enable is low
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_reg <= '0;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  assign x_rdata_out = state_reg.x_rdata;
  assign y_rdata_out = state_reg.y_rdata;
  assign dma_rdata_out = state_reg.dma_rdata;
  assign preg_wr_out = state_reg.preg_wr;
  assign collide_out = state_reg.collide;
  assign wr_err_out = state_reg.wr_err;

  // Helpers that remember what an assertion must compare against
  logic [AW-1:0] h_idx_reg;
  logic [15:0] h_data_reg;
  logic [7:0] h_hi_reg;
  logic [15:0] h_dma_reg;
  always_ff @(posedge clk_in) begin
    // Frozen with the rest of the block while the enable is low
    if (ce_in) begin
      h_idx_reg <= w_idx;
      h_data_reg <= wr_in.data;
      h_hi_reg <= mem[w_idx][15:8];
      h_dma_reg <= d_word;
    end
  end

  property p_preg_zero;
    @(posedge clk_in) disable iff (!resetn_in)
    (ce_in && x_rd_in.req && x_adr <= PREG_LAST && !preg_hit_in)
      |=> x_rdata_out == 16'h0000;
  endproperty
  a_preg_zero: assert property (p_preg_zero) // RL2
    else $error("unused register address did not read zero");

  property p_out_zero;
    @(posedge clk_in) disable iff (!resetn_in)
    (ce_in && x_rd_in.req && {1'b0, x_adr} >= RAM_TOP)
      |=> x_rdata_out == 16'h0000;
  endproperty
  a_out_zero: assert property (p_out_zero) // RL16
    else $error("read outside memory did not return zero");

  property p_near_range;
    @(posedge clk_in) disable iff (!resetn_in)
    (x_rd_in.mode == DSD_AM_NEAR) |-> x_adr <= NEAR_LAST;
  endproperty
  a_near_range: assert property (p_near_range) // RL3
    else $error("near address left the near region");

  property p_y_outside;
    @(posedge clk_in) disable iff (!resetn_in)
    (ce_in && y_rd_in.req && !in_y(y_rd_in.pointer))
      |=> y_rdata_out == 16'h0000;
  endproperty
  a_y_outside: assert property (p_y_outside) // RL8
    else $error("Y path answered outside Y space");

  property p_cpu_wins;
    @(posedge clk_in) disable iff (!resetn_in)
    (ce_in && collide_w && !wr_in.byte_op)
      |=> collide_out && mem[h_idx_reg] == h_data_reg;
  endproperty
  a_cpu_wins: assert property (p_cpu_wins) // RL14
    else $error("CPU write lost a collision with DMA");

  property p_bitrev_y;
    @(posedge clk_in) disable iff (!resetn_in)
    (ce_in && wr_in.req && wr_in.bitrev && in_y(w_adr))
      |=> wr_err_out && !preg_wr_out.we;
  endproperty
  a_bitrev_y: assert property (p_bitrev_y) // RL9
    else $error("bit-reversed write into Y was not refused");

  property p_byte_lane;
    @(posedge clk_in) disable iff (!resetn_in)
    (ce_in && cpu_we && wr_in.byte_op && !w_adr[0])
      |=> mem[h_idx_reg][15:8] == h_hi_reg;
  endproperty
  a_byte_lane: assert property (p_byte_lane) // RL17
    else $error("byte write disturbed the other lane");

  property p_preg_write;
    @(posedge clk_in) disable iff (!resetn_in)
    (ce_in && wr_in.req && w_adr <= PREG_LAST)
      |=> preg_wr_out.we && preg_wr_out.addr == $past(w_adr);
  endproperty
  a_preg_write: assert property (p_preg_write) // RL1
    else $error("register region write not passed out");

  property p_dma_read;
    @(posedge clk_in) disable iff (!resetn_in)
    (ce_in && dma_in.rd && x_rd_in.req)
      |=> dma_rdata_out == h_dma_reg;
  endproperty
  a_dma_read: assert property (p_dma_read) // RL13
    else $error("DMA read disturbed by concurrent CPU read");

  c_collide: cover property (@(posedge clk_in) ce_in && collide_w);
  c_dual_read: cover property (@(posedge clk_in)
    ce_in && x_rd_in.req && y_rd_in.req && in_y(y_rd_in.pointer));
  c_near_read: cover property (@(posedge clk_in)
    ce_in && x_rd_in.req && x_rd_in.mode == DSD_AM_NEAR);
  c_byte_write: cover property (@(posedge clk_in)
    ce_in && cpu_we && wr_in.byte_op && w_adr[0]);
endmodule
`default_nettype wire

// File: dv/dsd_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsd_periph_model (
  // Core side seen by the peripherals
  input wire logic clk_in,
  input wire dsd_pkg::dsd_rd_t x_rd_in,
  input wire dsd_pkg::dsd_preg_wr_t preg_wr_in,
  // Answers to the decoder
  output logic preg_hit_out,
  output logic [15:0] preg_rdata_out
);
  import dsd_pkg::*;
  logic [15:0] regs_reg [0:3];
  logic [15:0] adr;
  // Four registers at 0x0020..0x0027; every other register address misses
  always_comb begin
    case (x_rd_in.mode)
      DSD_AM_NEAR: adr = {3'h0, x_rd_in.near_addr};
      DSD_AM_DIRECT: adr = x_rd_in.direct_addr;
      DSD_AM_INDIRECT: adr = x_rd_in.pointer;
      default: adr = 16'h0000;
    endcase
    preg_hit_out = (adr[15:3] == 13'h0004);
    // A miss drives junk, so a decoder that leaks it is caught
    preg_rdata_out = preg_hit_out ? regs_reg[adr[2:1]] : 16'hA5C3;
  end
  // Whole-word capture is enough, the bench never writes bytes here
  always_ff @(posedge clk_in) begin
    if (preg_wr_in.we && preg_wr_in.addr[15:3] == 13'h0004) begin
      regs_reg[preg_wr_in.addr[2:1]] <= preg_wr_in.data;
    end
  end
endmodule
`default_nettype wire

// File: dv/data_space_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module data_space_decoder_test;
  import dsd_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  dsd_rd_t x_rd = '0;
  dsd_yrd_t y_rd = '0;
  dsd_wr_t wr = '0;
  dsd_dma_t dma = '0;
  dsd_preg_wr_t preg_wr;
  dsd_preg_wr_t pw_q;
  logic col_q, err_q;
  logic ce = 1'b1;
  logic hit, collide, wr_err;
  logic [15:0] prd, x_q, y_q, d_q;
  int fail_count = 0;
  int checks_done = 0;

  // 20 MHz core clock
  always #25 clk_in = ~clk_in;

  // Small RAM: 0x0800..0x08FF, Y from 0x0880, DMA RAM 0x08C0..0x08FF
  dsd_data_space #(.RAM_BYTES(256), .Y_BASE(16'h0880), .DMA_BYTES(64))
    dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce),
    .x_rd_in(x_rd), .y_rd_in(y_rd), .wr_in(wr), .preg_hit_in(hit),
    .preg_rdata_in(prd), .dma_in(dma), .x_rdata_out(x_q),
    .y_rdata_out(y_q), .dma_rdata_out(d_q), .preg_wr_out(preg_wr),
    .collide_out(collide), .wr_err_out(wr_err));

  dsd_periph_model periph_u (.clk_in(clk_in), .x_rd_in(x_rd),
    .preg_wr_in(preg_wr), .preg_hit_out(hit), .preg_rdata_out(prd));

  task automatic stop_test();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({15'h0000, got}, {15'h0000, exp});
  endtask

  // One taken edge; pulses are caught, strobes drop, and an idle edge
  // follows so no strobe is set and cleared in one time step. The idle
  // edge also lets the peripheral model take a register write.
  task automatic step();
    @(posedge clk_in);
    @(negedge clk_in);
    pw_q = preg_wr;
    col_q = collide;
    err_q = wr_err;
    x_rd.req = 1'b0;
    y_rd.req = 1'b0;
    wr.req = 1'b0;
    dma.rd = 1'b0;
    dma.wr = 1'b0;
    @(posedge clk_in);
    @(negedge clk_in);
  endtask

  // Unused address fields point at another word so a wrong mode shows
  task automatic rd(input dsd_mode_t m, input logic [15:0] a,
                    input logic bo, output logic [15:0] q);
    x_rd = '{1'b1, bo, m, (m == DSD_AM_NEAR) ? a[12:0] : 13'h0846,
             (m == DSD_AM_DIRECT) ? a : 16'h0846,
             (m == DSD_AM_INDIRECT) ? a : 16'h0846};
    step();
    q = x_q;
  endtask

  task automatic put(input dsd_mode_t m, input logic [15:0] a,
                     input logic bo, input logic br, input logic [15:0] d);
    wr = '{1'b1, bo, br, 1'b0, m, (m == DSD_AM_NEAR) ? a[12:0] : 13'h0846,
           (m == DSD_AM_DIRECT) ? a : 16'h0846,
           (m == DSD_AM_INDIRECT) ? a : 16'h0846, d};
  endtask

  task automatic wr_now(input dsd_mode_t m, input logic [15:0] a,
                        input logic bo, input logic br, input logic [15:0] d);
    put(m, a, bo, br, d);
    step();
  endtask

  task automatic t_regs();
    logic [15:0] q;
    wr_now(DSD_AM_DIRECT, 16'h0022, 1'b0, 1'b0, 16'h5A5A);
    cmp_bit(pw_q.we, 1'b1);
    cmp_word(pw_q.addr, 16'h0022);
    cmp_word(pw_q.data, 16'h5A5A);
    rd(DSD_AM_NEAR, 16'h0022, 1'b0, q);
    cmp_word(q, 16'h5A5A);
    rd(DSD_AM_NEAR, 16'h0100, 1'b0, q);
    cmp_word(q, 16'h0000);
    wr_now(DSD_AM_DIRECT, 16'h0800, 1'b0, 1'b0, 16'h0F0F);
    cmp_bit(pw_q.we, 1'b0);
  endtask

  task automatic t_modes_bytes();
    logic [15:0] q;
    wr_now(DSD_AM_NEAR, 16'h0810, 1'b0, 1'b0, 16'h1234);
    rd(DSD_AM_DIRECT, 16'h0810, 1'b0, q);
    cmp_word(q, 16'h1234);
    rd(DSD_AM_INDIRECT, 16'h0811, 1'b0, q);
    cmp_word(q, 16'h1234);
    wr_now(DSD_AM_INDIRECT, 16'h0811, 1'b1, 1'b0, 16'h00AB);
    rd(DSD_AM_DIRECT, 16'h0810, 1'b0, q);
    cmp_word(q, 16'hAB34);
    rd(DSD_AM_NEAR, 16'h0811, 1'b1, q);
    cmp_word(q, 16'h00AB);
    rd(DSD_AM_NEAR, 16'h0810, 1'b1, q);
    cmp_word(q, 16'h0034);
  endtask

  task automatic t_xy();
    logic [15:0] q;
    wr_now(DSD_AM_DIRECT, 16'h0880, 1'b0, 1'b0, 16'hC0DE);
    wr_now(DSD_AM_DIRECT, 16'h0820, 1'b0, 1'b0, 16'h1111);
    // Both paths taken on the same edge
    y_rd = '{1'b1, 16'h0880};
    rd(DSD_AM_DIRECT, 16'h0820, 1'b0, q);
    cmp_word(q, 16'h1111);
    cmp_word(y_q, 16'hC0DE);
    y_rd = '{1'b1, 16'h087E};
    step();
    cmp_word(y_q, 16'h0000);
    // Bit-reversed writes are allowed in X only
    wr_now(DSD_AM_DIRECT, 16'h0882, 1'b0, 1'b0, 16'h4444);
    wr_now(DSD_AM_DIRECT, 16'h0882, 1'b0, 1'b1, 16'h7777);
    cmp_bit(err_q, 1'b1);
    y_rd = '{1'b1, 16'h0882};
    step();
    cmp_bit(err_q, 1'b0);
    cmp_word(y_q, 16'h4444);
    wr_now(DSD_AM_INDIRECT, 16'h0830, 1'b0, 1'b1, 16'h2222);
    cmp_bit(err_q, 1'b0);
    rd(DSD_AM_DIRECT, 16'h0830, 1'b0, q);
    cmp_word(q, 16'h2222);
  endtask

  task automatic t_outside();
    logic [15:0] q;
    wr_now(DSD_AM_DIRECT, 16'h0900, 1'b0, 1'b0, 16'h9999);
    rd(DSD_AM_DIRECT, 16'h0900, 1'b0, q);
    cmp_word(q, 16'h0000);
    rd(DSD_AM_INDIRECT, 16'h8000, 1'b0, q);
    cmp_word(q, 16'h0000);
    // Enable low: the write is ignored, the word keeps its old value
    ce = 1'b0;
    wr_now(DSD_AM_DIRECT, 16'h0810, 1'b0, 1'b0, 16'hFFFF);
    ce = 1'b1;
    rd(DSD_AM_DIRECT, 16'h0810, 1'b0, q);
    cmp_word(q, 16'hAB34);
  endtask

  task automatic t_dma();
    wr_now(DSD_AM_DIRECT, 16'h08C0, 1'b0, 1'b0, 16'h1357);
    dma = '{1'b1, 1'b0, 1'b0, 11'h000, 16'h0000};
    step();
    cmp_word(d_q, 16'h1357);
    // Same word from both sides on one edge: the CPU keeps it
    put(DSD_AM_DIRECT, 16'h08C2, 1'b0, 1'b0, 16'hAAAA);
    dma = '{1'b0, 1'b1, 1'b0, 11'h002, 16'h5555};
    step();
    cmp_bit(col_q, 1'b1);
    dma = '{1'b1, 1'b0, 1'b0, 11'h002, 16'h0000};
    step();
    cmp_bit(col_q, 1'b0);
    cmp_word(d_q, 16'hAAAA);
    // Different words on one edge: both land, no stall
    put(DSD_AM_DIRECT, 16'h08C4, 1'b0, 1'b0, 16'h0C0C);
    dma = '{1'b0, 1'b1, 1'b0, 11'h006, 16'h6060};
    step();
    cmp_bit(col_q, 1'b0);
    y_rd = '{1'b1, 16'h08C6};
    dma = '{1'b1, 1'b0, 1'b0, 11'h004, 16'h0000};
    step();
    cmp_word(y_q, 16'h6060);
    cmp_word(d_q, 16'h0C0C);
    // DMA byte write into the high lane spares the low byte
    dma = '{1'b0, 1'b1, 1'b1, 11'h005, 16'h00EE};
    step();
    dma = '{1'b1, 1'b0, 1'b0, 11'h004, 16'h0000};
    step();
    cmp_word(d_q, 16'hEE0C);
  endtask

  // Cut a hang short
  initial begin
    repeat (5000) @(posedge clk_in);
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (6) @(negedge clk_in);
    resetn_in = 1'b1;
    t_regs();
    t_modes_bytes();
    t_xy();
    t_outside();
    t_dma();
    stop_test();
  end
endmodule
`default_nettype wire
